/* core/flash_read_consts.svh */
// Opcodes, dummy lengths, field limits and reset values of the continuous array read front end.
`ifndef FLASH_READ_CONSTS_SVH
`define FLASH_READ_CONSTS_SVH

// Continuous array read opcodes.
`define OPC_READ_LEGACY 8'he8
`define OPC_READ_FASTEST 8'h1b
`define OPC_READ_FAST 8'h0b
`define OPC_READ_SLOW 8'h03

// Dummy bits that follow the address for each opcode.
`define DUMMY_BITS_LEGACY 6'h20
`define DUMMY_BITS_FASTEST 6'h10
`define DUMMY_BITS_FAST 6'h08
`define DUMMY_BITS_SLOW 6'h00

// Serial bit positions of the last opcode and last address bit.
`define OPC_LAST_BIT 6'h07
`define ADDR_LAST_BIT 6'h17

// Link bit totals from select to first data bit.
`define FRAME_BITS_LEGACY 7'h40
`define FRAME_BITS_FASTEST 7'h30
`define FRAME_BITS_FAST 7'h28
`define FRAME_BITS_SLOW 7'h20
`define FRAME_BITS_MAX 7'h7f

// Page geometry: last byte offset in a page and last page index.
`define LAST_BYTE_264 9'h107
`define LAST_BYTE_256 9'h0ff
`define LAST_PAGE 15'h7fff

// Stream buffer geometry and filler byte for an under-run.
`define FIFO_DEPTH 16
`define FIFO_WIDTH 9
`define FILL_BYTE 8'hff

// Reset values.
`define ADDR_RESET 24'h000000
`define SHIFT_RESET 8'h00

`endif

/* core/flash_read_pkg.sv */
// Types shared by the continuous array read front end.
package flash_read_pkg;

  // Link-side command phases, Gray coded along opcode, address, dummy, data.
  typedef enum logic [2:0] {
    LS_OPC = 3'b000,
    LS_ADDR = 3'b001,
    LS_DUMMY = 3'b011,
    LS_DATA = 3'b010,
    LS_IGNORE = 3'b110
  } link_state_t;

endpackage

/* core/serial_flash_continuous_read.sv */
// Continuous array read front end with its clock-crossing stream buffer.
//
// Overview of operation
// - Address counter advances per byte fetched into the stream buffer.
// - Legacy opcode: address, then four dummy bytes.
// - 264-byte pages: 15-bit page, 9-bit byte.
// - 256-byte pages: 23-bit linear address used.
// - Dummy bytes only initialise; data follows them.
// - Page end continues at next page, no gap.
// - Array end wraps to first page, no gap.
// - Select rising ends read, releases output.
// - Reads come from array, buffers untouched.
// - Fastest opcode: address, then two dummy bytes.
// - Fast opcode: address, then one dummy byte.
// - Slow opcode: address, then data directly.
// - Works in clock mode 0 and 3.
// - Select fall starts command, opcode first.
// - All fields shift most significant bit first.
`timescale 1ns/100ps
`default_nettype none
`include "flash_read_consts.svh"

// Dual-clock FIFO with Gray-coded pointers; the write side runs on the core clock.
module stream_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic wr_clk_in, // Write clock.
  input wire logic wr_rst_n_in, // Synchronous write-side reset, low active.
  input wire logic wr_ce_in, // Write-side clock enable.
  input wire logic wr_valid_in, // Write word offered.
  output logic wr_ready_out, // Room for a word.
  input wire logic [WIDTH-1:0] wr_data_in, // Write word.
  input wire logic rd_clk_in, // Read clock.
  input wire logic rd_rst_n_in, // Asynchronous read-side reset, low active.
  output logic rd_valid_out, // Head word present.
  input wire logic rd_ready_in, // Head word taken.
  output logic [WIDTH-1:0] rd_data_out // Head word.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin;
  logic [AW:0] wgray;
  logic [AW:0] rgray_w1;
  logic [AW:0] rgray_w2;
  logic [AW:0] rbin;
  logic [AW:0] rgray;
  logic [AW:0] wgray_r1;
  logic [AW:0] wgray_r2;
  logic push;
  logic pop;

  function automatic logic [AW:0] gray_f(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Full compares against the read pointer with its two top bits inverted.
  assign wr_ready_out = (wgray != {~rgray_w2[AW:AW-1], rgray_w2[AW-2:0]});
  assign rd_valid_out = (rgray != wgray_r2);
  assign rd_data_out = mem[rbin[AW-1:0]];
  assign push = wr_valid_in && wr_ready_out && wr_ce_in;
  assign pop = rd_valid_out && rd_ready_in;

  // Write pointer and the read pointer brought over on two flip-flops.
  always_ff @(posedge wr_clk_in) begin
    if (!wr_rst_n_in) begin
      wbin <= '0;
      wgray <= '0;
      rgray_w1 <= '0;
      rgray_w2 <= '0;
    end else if (wr_ce_in) begin
      rgray_w1 <= rgray;
      rgray_w2 <= rgray_w1;
      if (push) begin
        wbin <= wbin + 1'b1;
        wgray <= gray_f(wbin + 1'b1);
      end
    end
  end

  // Storage is written only by the write side.
  always_ff @(posedge wr_clk_in) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= wr_data_in;
    end
  end

  // Read pointer and the write pointer brought over on two flip-flops.
  always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
    if (!rd_rst_n_in) begin
      rbin <= '0;
      rgray <= '0;
      wgray_r1 <= '0;
      wgray_r2 <= '0;
    end else begin
      wgray_r1 <= wgray;
      wgray_r2 <= wgray_r1;
      if (pop) begin
        rbin <= rbin + 1'b1;
        rgray <= gray_f(rbin + 1'b1);
      end
    end
  end
endmodule

// Serial command decoder on the link clock and array fetcher on the core clock.
module serial_flash_continuous_read
  import flash_read_pkg::*;
(
  input wire logic ref_clk_in, // Core clock, 20 MHz.
  input wire logic resetn_in, // Reset, low active; synchronous on the core clock, asynchronous on the link clock.
  input wire logic ce_in, // Core clock enable.
  input wire logic sck_in, // Serial link clock.
  input wire logic cs_n_in, // Chip select, low active.
  input wire logic si_in, // Serial data in.
  output logic so_out, // Serial data out.
  output logic so_oe_out, // Serial output enable.
  input wire logic page_264_in, // High selects 264-byte pages.
  output logic array_rd_out, // Array read strobe.
  output logic [23:0] array_addr_out, // Array page and byte address.
  input wire logic [7:0] array_data_in // Array byte, valid one cycle after the strobe.
);
  // Link-clock state.
  link_state_t state;
  logic [5:0] cnt;
  logic [7:0] shreg;
  logic [7:0] opcode;
  logic [5:0] dummy_bits;
  logic [6:0] frame_bits;
  logic [23:0] addr_sh;
  logic [23:0] addr_hold;
  logic start_tgl;
  logic epoch;
  logic [7:0] tx_byte;
  logic [6:0] opc_info;
  logic addr_done;
  logic [7:0] head_byte;
  logic head_stale;
  // Core-clock state.
  logic start_s1;
  logic start_s2;
  logic start_s3;
  logic cs_s1;
  logic cs_s2;
  logic pg_s1;
  logic pg_s2;
  logic running;
  logic [1:0] pend;
  logic [23:0] cur;
  logic wr_epoch;
  logic start_ev;
  logic issue;
  logic wr_ready;
  logic rd_valid;
  logic rd_ready;
  logic [8:0] rd_data;

  // Valid flag and dummy length of an opcode.
  function automatic logic [6:0] opcode_info_f(input logic [7:0] op);
    case (op)
      `OPC_READ_LEGACY: return {1'b1, `DUMMY_BITS_LEGACY};
      `OPC_READ_FASTEST: return {1'b1, `DUMMY_BITS_FASTEST};
      `OPC_READ_FAST: return {1'b1, `DUMMY_BITS_FAST};
      `OPC_READ_SLOW: return {1'b1, `DUMMY_BITS_SLOW};
      default: return 7'h00;
    endcase
  endfunction

  // Last byte offset of a page for the selected page size.
  function automatic logic [8:0] last_byte_f(input logic is264);
    return is264 ? `LAST_BYTE_264 : `LAST_BYTE_256;
  endfunction

  // Splits the received address into page and byte fields.
  function automatic logic [23:0] decode_f(input logic [23:0] a, input logic is264);
    if (is264) begin
      return a;
    end
    return {a[22:8], 1'b0, a[7:0]};
  endfunction

  // Next array location: next page after a page end, page zero after the array end.
  function automatic logic [23:0] next_addr_f(input logic [23:0] a, input logic is264);
    if (a[8:0] == last_byte_f(is264)) begin
      return {a[23:9] + 15'h0001, 9'h000};
    end
    return {a[23:9], a[8:0] + 9'h001};
  endfunction

  assign opc_info = opcode_info_f({shreg[6:0], si_in});
  assign addr_done = (state == LS_ADDR) && (cnt == `ADDR_LAST_BIT);
  assign head_stale = rd_valid && (rd_data[8] != epoch);
  assign head_byte = (rd_valid && !head_stale) ? rd_data[7:0] : `FILL_BYTE;
  // Stale words of an earlier command drain on every rising link edge; fresh ones go once per byte.
  assign rd_ready = head_stale || ((state == LS_DATA) && (cnt[2:0] == 3'h0));

  // Inputs are sampled on the rising link edge, which suits clock modes 0 and 3.
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      state <= LS_OPC;
      cnt <= 6'h00;
      shreg <= `SHIFT_RESET;
      opcode <= `SHIFT_RESET;
      dummy_bits <= 6'h00;
      frame_bits <= 7'h00;
      addr_sh <= `ADDR_RESET;
    end else begin
      frame_bits <= (frame_bits == `FRAME_BITS_MAX) ? frame_bits : frame_bits + 7'h01;
      case (state)
        LS_OPC: begin
          shreg <= {shreg[6:0], si_in};
          cnt <= cnt + 6'h01;
          if (cnt == `OPC_LAST_BIT) begin
            cnt <= 6'h00;
            opcode <= {shreg[6:0], si_in};
            dummy_bits <= opc_info[5:0];
            state <= opc_info[6] ? LS_ADDR : LS_IGNORE;
          end
        end
        LS_ADDR: begin
          addr_sh <= {addr_sh[22:0], si_in};
          cnt <= cnt + 6'h01;
          if (addr_done) begin
            cnt <= 6'h00;
            state <= (dummy_bits == 6'h00) ? LS_DATA : LS_DUMMY;
          end
        end
        LS_DUMMY: begin
          cnt <= cnt + 6'h01;
          if (cnt == dummy_bits - 6'h01) begin
            cnt <= 6'h00;
            state <= LS_DATA;
          end
        end
        LS_DATA: begin
          cnt <= cnt + 6'h01;
        end
        default: begin
          state <= LS_IGNORE;
        end
      endcase
    end
  end

  // Hands the start address over; the address stays put until the next command.
  always_ff @(posedge sck_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_tgl <= 1'b0;
      epoch <= 1'b0;
      addr_hold <= `ADDR_RESET;
    end else if (addr_done) begin
      start_tgl <= ~start_tgl;
      epoch <= ~epoch;
      addr_hold <= {addr_sh[22:0], si_in};
    end
  end

  // Output shifts on the falling link edge, most significant bit first.
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
      tx_byte <= `SHIFT_RESET;
    end else if (state == LS_DATA) begin
      so_oe_out <= 1'b1;
      if (cnt[2:0] == 3'h0) begin
        tx_byte <= head_byte;
        so_out <= head_byte[7];
      end else begin
        so_out <= tx_byte[3'h7 - cnt[2:0]];
      end
    end
  end

  // Level and event crossings into the core clock, two flip-flops each.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      pg_s1 <= 1'b1;
      pg_s2 <= 1'b1;
    end else if (ce_in) begin
      start_s1 <= start_tgl;
      start_s2 <= start_s1;
      start_s3 <= start_s2;
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      pg_s1 <= page_264_in;
      pg_s2 <= pg_s1;
    end
  end

  assign start_ev = start_s2 ^ start_s3;
  assign issue = running && !cs_s2 && (pend == 2'b00) && wr_ready && !start_ev;

  // Fetches array bytes straight into the stream buffer; the page buffers are never touched.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      running <= 1'b0;
      pend <= 2'b00;
      cur <= `ADDR_RESET;
      wr_epoch <= 1'b0;
      array_rd_out <= 1'b0;
      array_addr_out <= `ADDR_RESET;
    end else if (ce_in) begin
      array_rd_out <= 1'b0;
      pend <= {pend[0], 1'b0};
      if (start_ev) begin
        running <= 1'b1;
        pend <= 2'b00;
        cur <= decode_f(addr_hold, pg_s2);
        wr_epoch <= epoch;
      end else begin
        if (cs_s2) begin
          running <= 1'b0;
        end
        if (issue) begin
          array_rd_out <= 1'b1;
          array_addr_out <= cur;
          cur <= next_addr_f(cur, pg_s2);
          pend <= {pend[0], 1'b1};
        end
      end
    end
  end

  stream_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_stream_fifo (
    .wr_clk_in(ref_clk_in),
    .wr_rst_n_in(resetn_in),
    .wr_ce_in(ce_in),
    .wr_valid_in(pend[1]),
    .wr_ready_out(wr_ready),
    .wr_data_in({wr_epoch, array_data_in}),
    .rd_clk_in(sck_in),
    .rd_rst_n_in(resetn_in),
    .rd_valid_out(rd_valid),
    .rd_ready_in(rd_ready),
    .rd_data_out(rd_data)
  );

  // Checks on the link side: the first data edge lands after the exact header length, and data goes out high bit first.
  chk_legacy_dummies: assert property (@(posedge sck_in) disable iff (cs_n_in)
    (state == LS_DATA && $past(state) != LS_DATA && opcode == `OPC_READ_LEGACY) |->
      frame_bits == `FRAME_BITS_LEGACY) else $error("Legacy read header length wrong.");
  chk_fastest_dummies: assert property (@(posedge sck_in) disable iff (cs_n_in)
    (state == LS_DATA && $past(state) != LS_DATA && opcode == `OPC_READ_FASTEST) |->
      frame_bits == `FRAME_BITS_FASTEST) else $error("Fastest read header length wrong.");
  chk_fast_dummies: assert property (@(posedge sck_in) disable iff (cs_n_in)
    (state == LS_DATA && $past(state) != LS_DATA && opcode == `OPC_READ_FAST) |->
      frame_bits == `FRAME_BITS_FAST) else $error("Fast read header length wrong.");
  chk_slow_no_dummies: assert property (@(posedge sck_in) disable iff (cs_n_in)
    (state == LS_DATA && $past(state) != LS_DATA && opcode == `OPC_READ_SLOW) |->
      frame_bits == `FRAME_BITS_SLOW) else $error("Slow read header length wrong.");
  chk_msb_first_out: assert property (@(posedge sck_in) disable iff (cs_n_in)
    (state == LS_DATA && cnt[2:0] == 3'h0) |-> so_out == tx_byte[7] && so_oe_out)
    else $error("Data byte not sent high bit first.");

  // Checks on the core side: release, address load and counter stepping.
  chk_so_release: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    cs_s2 |-> !so_oe_out) else $error("Output driven while deselected.");
  chk_load_264: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ce_in && start_ev && pg_s2) |=> cur == addr_hold) else $error("Bad 264-byte page decode.");
  chk_load_256: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ce_in && start_ev && !pg_s2) |=> cur == {addr_hold[22:8], 1'b0, addr_hold[7:0]})
    else $error("Bad 256-byte page decode.");
  chk_addr_step: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ce_in && issue) |=> array_rd_out && array_addr_out == $past(cur) && cur != $past(cur))
    else $error("Read counter did not advance.");
  chk_page_cross: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ce_in && issue && cur[8:0] == last_byte_f(pg_s2) && cur[23:9] != `LAST_PAGE) |=>
      cur == {$past(cur[23:9]) + 15'h0001, 9'h000}) else $error("Page crossover wrong.");
  chk_array_wrap: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ce_in && issue && cur == {`LAST_PAGE, last_byte_f(pg_s2)}) |=> cur == `ADDR_RESET)
    else $error("Array wrap wrong.");
endmodule

`default_nettype wire

/* dv/serial_flash_continuous_read_tb.sv */
// Self-checking bench for the continuous array read front end.
`timescale 1ns/100ps
`default_nettype none
`include "flash_read_consts.svh"
module serial_flash_continuous_read_tb;
  logic ref_clk_in, resetn_in, ce_in, page_264_in;
  logic sck_in, cs_n_in, si_in, so_out, so_oe_out, array_rd_out;
  logic [23:0] array_addr_out;
  logic [7:0] array_data_in;
  int n_mismatch;
  int check_count;
  int cycles;

  serial_flash_continuous_read dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .page_264_in(page_264_in), .array_rd_out(array_rd_out), .array_addr_out(array_addr_out),
    .array_data_in(array_data_in));

  spi_host_model host (.sck_out(sck_in), .cs_n_out(cs_n_in), .si_out(si_in), .so_in(so_out),
    .so_oe_in(so_oe_out));

  // Array content: never 0xff, so filler bytes stand out from real data.
  function automatic logic [7:0] pat(input logic [23:0] a);
    return {1'b0, a[6:0] ^ a[15:9] ^ a[22:16] ^ {a[23], 5'h00, a[8]}};
  endfunction

  // Next {page, byte} address of the stream.
  function automatic logic [23:0] nxt(input logic [23:0] a, input logic p264);
    logic [8:0] last;
    last = p264 ? `LAST_BYTE_264 : `LAST_BYTE_256;
    if (a[8:0] != last) return a + 24'h000001;
    return {a[23:9] + 15'h0001, 9'h000};
  endfunction

  // Array stand-in answers one cycle after the strobe and scrambles the bus otherwise.
  always @(posedge ref_clk_in) begin
    if (array_rd_out === 1'b1) array_data_in <= #2 pat(array_addr_out);
    else array_data_in <= #2 ~array_data_in;
  end

  // Core clock, 50 ns period.
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // Hang guard.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One read frame, then the stream is compared from its first fresh byte onward.
  task automatic run_read(input logic [7:0] opc, input int nd, input logic p264, input logic m3,
                          input logic [23:0] adr);
    logic [23:0] a;
    int j;
    @(posedge ref_clk_in);
    #2 page_264_in = p264;
    repeat (4) @(posedge ref_clk_in);
    host.frame(opc, adr, nd, 10, m3);
    #1;
    chk("released enable", 32'h0, {31'h0, so_oe_out});
    chk("released data", 32'h0, {31'h0, so_out});
    chk("early enable", 32'h0, host.oe_early);
    chk("data enable", 32'h0, host.oe_miss);
    a = p264 ? adr : {adr[22:8], 1'b0, adr[7:0]};
    j = 0;
    while (j < 10 && host.rx[j] === 8'hff) j++;
    chk("filler count low", 32'h1, {31'h0, j <= 3});
    for (; j < 10; j++) begin
      chk("stream byte", {24'h0, pat(a)}, {24'h0, host.rx[j]});
      a = nxt(a, p264);
    end
  endtask

  task automatic sc_opcodes();
    run_read(`OPC_READ_LEGACY, 4, 1'b1, 1'b0, {15'h0012, 9'h0a3});
    run_read(`OPC_READ_FASTEST, 2, 1'b1, 1'b0, {15'h0012, 9'h0a3});
    run_read(`OPC_READ_FAST, 1, 1'b1, 1'b0, {15'h0012, 9'h0a3});
    run_read(`OPC_READ_SLOW, 0, 1'b1, 1'b0, {15'h0012, 9'h0a3});
  endtask

  task automatic sc_cross_264();
    run_read(`OPC_READ_FAST, 1, 1'b1, 1'b1, {15'h0005, 9'h104});
  endtask

  task automatic sc_cross_256();
    run_read(`OPC_READ_LEGACY, 4, 1'b0, 1'b1, {1'b0, 15'h0033, 8'hfc});
  endtask

  task automatic sc_wrap();
    run_read(`OPC_READ_FASTEST, 2, 1'b1, 1'b0, {15'h7fff, 9'h104});
    run_read(`OPC_READ_SLOW, 0, 1'b0, 1'b1, {1'b0, 15'h7fff, 8'hfd});
  endtask

  // An unknown opcode leaves the output released for the whole frame.
  task automatic sc_refuse();
    host.frame(8'h52, 24'h000100, 0, 4, 1'b0);
    chk("refused enable", 32'h0, host.oe_early);
    chk("refused data phase", 32'd32, host.oe_miss);
    run_read(`OPC_READ_FAST, 1, 1'b1, 1'b0, 24'h000000);
  endtask

  // Main sequence.
  initial begin
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    resetn_in = 1'b0;
    ce_in = 1'b1;
    page_264_in = 1'b1;
    array_data_in = 8'h00;
    repeat (12) @(posedge ref_clk_in);
    #2 resetn_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #2;
    sc_opcodes();
    sc_cross_264();
    sc_cross_256();
    sc_wrap();
    sc_refuse();
    end_sim();
  end
endmodule
`default_nettype wire

/* dv/spi_host_model.sv */
// Host serial controller model that frames continuous read commands on the link.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic sck_out, // Link clock, runs only inside frames.
  output logic cs_n_out, // Chip select, low active.
  output logic si_out, // Serial data to the device.
  input wire logic so_in, // Serial data from the device.
  input wire logic so_oe_in // Device output enable.
);
  logic [7:0] rx [0:31];
  int oe_early;
  int oe_miss;

  // Idle link: deselected, clock stopped.
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    oe_early = 0;
    oe_miss = 0;
  end

  // One link cycle: the falling half changes si, the rising half samples so.
  task automatic bit_cycle(input logic b, output logic s);
    sck_out = 1'b0;
    si_out = b;
    #32;
    sck_out = 1'b1;
    s = so_in;
    #32;
  endtask

  // Whole frame: opcode, address, dummy bytes, then nrx data bytes; m3 picks clock mode 3.
  task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int nd, input int nrx,
                       input logic m3);
    logic [31:0] hdr;
    logic s;
    hdr = {opc, adr};
    oe_early = 0;
    oe_miss = 0;
    sck_out = m3;
    #20;
    cs_n_out = 1'b0;
    #32;
    for (int i = 31; i >= 0; i--) begin
      bit_cycle(hdr[i], s);
      if (so_oe_in !== 1'b0) oe_early++;
    end
    // Dummy bits carry no meaning, so the line toggles every cycle.
    for (int i = 0; i < nd * 8; i++) begin
      bit_cycle(~si_out, s);
      if (so_oe_in !== 1'b0) oe_early++;
    end
    for (int j = 0; j < nrx; j++) begin
      for (int k = 7; k >= 0; k--) begin
        bit_cycle(~si_out, s);
        rx[j][k] = s;
        if (so_oe_in !== 1'b1) oe_miss++;
      end
    end
    sck_out = m3;
    #32;
    cs_n_out = 1'b1;
    si_out = ~si_out;
  endtask
endmodule
`default_nettype wire
